// file: design/ubrg_sampler.sv
`timescale 1ns/100ps
`default_nettype none
module ubrg_sampler
    import ubrg_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic sample,
    input wire logic last,
    input wire logic din,
    output logic level_q,
    output logic valid_q
);

    // ==========================================================
    // Three-sample majority vote
    // ==========================================================
    logic [UBRG_VOTE_SAMPLES-1:0] shift_q, shift_d;
    logic level_d, valid_d;
    logic [UBRG_VOTE_SAMPLES-1:0] cand;

    always_comb begin
        shift_d = shift_q;
        level_d = level_q;
        valid_d = 1'b0;
        cand = {shift_q[UBRG_VOTE_SAMPLES-2:0], din};
        if (sample) begin
            shift_d = cand;
        end
        // Vote on the third sample, including the one arriving now
        if (sample && last) begin
            level_d = (cand[0] & cand[1]) | (cand[0] & cand[2]) | (cand[1] & cand[2]);
            valid_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            shift_q <= '1;
            level_q <= 1'b1;
            valid_q <= 1'b0;
        end else begin
            shift_q <= shift_d;
            level_q <= level_d;
            valid_q <= valid_d;
        end
    end

endmodule
`default_nettype wire

// file: design/ubrg_top.sv
// Function
// - Receive pin sampled three times per bit, level decided by majority vote.
// - Bit-rate tick derived from the system clock, scaling with its frequency.
// - Async, 8-bit divisor, low speed: rate is clock over 64 times (n+1).
// - Async 8-bit high speed or 16-bit low speed: clock over 16 times (n+1).
// - Sync mode: clock over 4 times (n+1), high-speed bit ignored.
// - With wide select, divisor n is divisor high byte above divisor low byte.
// - Unimplemented bits of control and status registers read as zero.
// - Default 8-bit divisor from low byte; wide select enables both bytes.
// - Writing either divisor byte clears the divisor timer at once.
// - Divisor timer runs freely, reload period set by the divisor pair.
// - Sync formula only as clock master; slave takes its clock from outside.
`timescale 1ns/100ps
`default_nettype none
module ubrg_top
    import ubrg_pkg::*;
#(
    parameter int DIVISOR_WIDTH = 16
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic rx_pin,
    output logic bit_tick_q,
    output logic rx_level_q,
    output logic rx_level_valid_q,
    output logic clock_out_q,
    output logic clock_out_en_q
);

    // ==========================================================
    // Receive pin synchroniser
    // ==========================================================
    logic rx_meta_q, rx_sync_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            rx_meta_q <= 1'b1;
            rx_sync_q <= 1'b1;
        end else begin
            rx_meta_q <= rx_pin;
            rx_sync_q <= rx_meta_q;
        end
    end

    // ==========================================================
    // Avalon-MM slave: one wait state on every access
    // ==========================================================
    logic wait_q, wait_d;
    logic [31:0] rdata_q, rdata_d;
    logic [7:0] tx_ctl_q, tx_ctl_d;
    logic [7:0] rx_ctl_q, rx_ctl_d;
    logic [7:0] baud_ctl_q, baud_ctl_d;
    logic [7:0] div_hi_q, div_hi_d;
    logic [7:0] div_lo_q, div_lo_d;
    logic req, commit, wr_commit;
    logic [7:0] rd_byte;
    logic [7:0] rate_status;
    logic divisor_write;

    assign req = avs_read | avs_write;
    // Second cycle of the request: waitrequest already low
    assign commit = req & ~wait_q;
    assign wr_commit = commit & avs_write & avs_byteenable[0];

    always_comb begin
        rd_byte = 8'h00;
        case (avs_address)
            UBRG_OFS_TX_STATUS_CONTROL: begin
                rd_byte = tx_ctl_q & UBRG_WMASK_TX;
                rd_byte[UBRG_TX_SHIFT_EMPTY] = 1'b1;
            end
            UBRG_OFS_RX_STATUS_CONTROL: begin
                rd_byte = rx_ctl_q & UBRG_WMASK_RX;
            end
            UBRG_OFS_BAUD_CONTROL: begin
                rd_byte = baud_ctl_q & UBRG_WMASK_BC;
                rd_byte[UBRG_BC_RECEIVE_IDLE] = 1'b1;
            end
            UBRG_OFS_BAUD_DIVISOR_HIGH: begin
                rd_byte = div_hi_q;
            end
            UBRG_OFS_BAUD_DIVISOR_LOW: begin
                rd_byte = div_lo_q;
            end
            UBRG_OFS_RATE_STATUS: begin
                rd_byte = rate_status;
            end
            default: begin
                rd_byte = 8'h00;
            end
        endcase
    end

    always_comb begin
        wait_d = 1'b1;
        rdata_d = rdata_q;
        // Drop waitrequest for exactly one cycle per request
        if (req && wait_q) begin
            wait_d = 1'b0;
            rdata_d = {24'h000000, rd_byte};
        end
    end

    always_comb begin
        tx_ctl_d = tx_ctl_q;
        rx_ctl_d = rx_ctl_q;
        baud_ctl_d = baud_ctl_q;
        div_hi_d = div_hi_q;
        div_lo_d = div_lo_q;
        divisor_write = 1'b0;
        if (wr_commit) begin
            case (avs_address)
                UBRG_OFS_TX_STATUS_CONTROL: begin
                    tx_ctl_d = avs_writedata[7:0] & UBRG_WMASK_TX;
                end
                UBRG_OFS_RX_STATUS_CONTROL: begin
                    rx_ctl_d = avs_writedata[7:0] & UBRG_WMASK_RX;
                end
                UBRG_OFS_BAUD_CONTROL: begin
                    baud_ctl_d = avs_writedata[7:0] & UBRG_WMASK_BC;
                end
                UBRG_OFS_BAUD_DIVISOR_HIGH: begin
                    div_hi_d = avs_writedata[7:0];
                    divisor_write = 1'b1;
                end
                UBRG_OFS_BAUD_DIVISOR_LOW: begin
                    div_lo_d = avs_writedata[7:0];
                    divisor_write = 1'b1;
                end
                default: begin
                    // Unmapped writes are dropped
                    divisor_write = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h00000000;
            tx_ctl_q <= UBRG_RST_TX_STATUS_CONTROL;
            rx_ctl_q <= UBRG_RST_RX_STATUS_CONTROL;
            baud_ctl_q <= UBRG_RST_BAUD_CONTROL;
            div_hi_q <= UBRG_RST_DIVISOR;
            div_lo_q <= UBRG_RST_DIVISOR;
        end else begin
            wait_q <= wait_d;
            rdata_q <= rdata_d;
            tx_ctl_q <= tx_ctl_d;
            rx_ctl_q <= rx_ctl_d;
            baud_ctl_q <= baud_ctl_d;
            div_hi_q <= div_hi_d;
            div_lo_q <= div_lo_d;
        end
    end

    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;

    // ==========================================================
    // Mode decode
    // ==========================================================
    ubrg_cfg_s cfg;
    logic [DIVISOR_WIDTH-1:0] divisor;
    logic [5:0] pre_last;
    logic [5:0] pre_half;
    logic [DIVISOR_WIDTH-1:0] div_mid;
    logic sync_master, sync_slave;

    assign cfg.sync_mode = tx_ctl_q[UBRG_TX_SYNC_MODE];
    assign cfg.clock_source_master = tx_ctl_q[UBRG_TX_CLOCK_SOURCE_MASTER];
    assign cfg.high_speed_select = tx_ctl_q[UBRG_TX_HIGH_SPEED_SELECT];
    assign cfg.wide_divisor_select = baud_ctl_q[UBRG_BC_WIDE_DIVISOR_SELECT];

    assign sync_master = cfg.sync_mode & cfg.clock_source_master;
    assign sync_slave = cfg.sync_mode & ~cfg.clock_source_master;

    // High byte above low byte; high byte ignored when narrow
    always_comb begin
        if (cfg.wide_divisor_select) begin
            divisor = DIVISOR_WIDTH'({div_hi_q, div_lo_q});
        end else begin
            divisor = DIVISOR_WIDTH'({8'h00, div_lo_q});
        end
    end

    always_comb begin
        if (cfg.sync_mode) begin
            pre_last = UBRG_PRE_LAST_SYNC;
        end else if (cfg.wide_divisor_select && cfg.high_speed_select) begin
            pre_last = UBRG_PRE_LAST_SYNC;
        end else if (cfg.wide_divisor_select || cfg.high_speed_select) begin
            pre_last = UBRG_PRE_LAST_FAST;
        end else begin
            pre_last = UBRG_PRE_LAST_SLOW;
        end
    end

    assign pre_half = 6'((7'(pre_last) + 7'h01) >> 1);
    assign div_mid = divisor >> 1;

    // ==========================================================
    // Free-running divisor timer
    // ==========================================================
    logic [5:0] pre_q, pre_d;
    logic [DIVISOR_WIDTH-1:0] cnt_q, cnt_d;
    logic tick_d;
    logic pre_wrap;

    assign pre_wrap = pre_q >= pre_last;

    always_comb begin
        pre_d = pre_q + 6'h01;
        cnt_d = cnt_q;
        tick_d = 1'b0;
        if (divisor_write) begin
            pre_d = 6'h00;
            cnt_d = '0;
        end else if (pre_wrap) begin
            pre_d = 6'h00;
            if (cnt_q >= divisor) begin
                cnt_d = '0;
                tick_d = ~sync_slave;
            end else begin
                cnt_d = cnt_q + DIVISOR_WIDTH'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pre_q <= 6'h00;
            cnt_q <= '0;
            bit_tick_q <= 1'b0;
        end else begin
            pre_q <= pre_d;
            cnt_q <= cnt_d;
            bit_tick_q <= tick_d;
        end
    end

    // ==========================================================
    // Synchronous master clock output
    // ==========================================================
    logic clk_out_d, clk_en_d;

    always_comb begin
        clk_out_d = clock_out_q;
        clk_en_d = sync_master;
        if (!sync_master || divisor_write) begin
            clk_out_d = 1'b0;
        end else if (tick_d) begin
            clk_out_d = 1'b1;
        end else if (cnt_q == div_mid && pre_q == pre_half) begin
            clk_out_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            clock_out_q <= 1'b0;
            clock_out_en_q <= 1'b0;
        end else begin
            clock_out_q <= clk_out_d;
            clock_out_en_q <= clk_en_d;
        end
    end

    // ==========================================================
    // Receive sampling around bit centre
    // ==========================================================
    logic samp_now, samp_last;
    logic at_mid;

    assign at_mid = cnt_q == div_mid;
    assign samp_now = at_mid & ~divisor_write &
                      ((pre_q == pre_half - 6'h01) | (pre_q == pre_half) |
                       (pre_q == pre_half + 6'h01));
    assign samp_last = pre_q == pre_half + 6'h01;

    ubrg_sampler u_sampler (
        .clk(clk),
        .srst(srst),
        .sample(samp_now),
        .last(samp_last),
        .din(rx_sync_q),
        .level_q(rx_level_q),
        .valid_q(rx_level_valid_q)
    );

    always_comb begin
        rate_status = 8'h00;
        rate_status[UBRG_RS_RX_LEVEL] = rx_level_q;
        rate_status[UBRG_RS_SYNC_MASTER] = sync_master;
        rate_status[UBRG_RS_SYNC_SLAVE] = sync_slave;
        rate_status[UBRG_RS_CLOCK_OUT] = clock_out_q;
    end

endmodule
`default_nettype wire

// file: shared/ubrg_pkg.sv
package ubrg_pkg;

    // ==========================================================
    // Register map (byte addresses, one 32-bit word each)
    // ==========================================================
    localparam logic [4:0] UBRG_OFS_TX_STATUS_CONTROL = 5'h00;
    localparam logic [4:0] UBRG_OFS_RX_STATUS_CONTROL = 5'h04;
    localparam logic [4:0] UBRG_OFS_BAUD_CONTROL = 5'h08;
    localparam logic [4:0] UBRG_OFS_BAUD_DIVISOR_HIGH = 5'h0c;
    localparam logic [4:0] UBRG_OFS_BAUD_DIVISOR_LOW = 5'h10;
    localparam logic [4:0] UBRG_OFS_RATE_STATUS = 5'h14;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int UBRG_TX_CLOCK_SOURCE_MASTER = 7;
    localparam int UBRG_TX_SYNC_MODE = 4;
    localparam int UBRG_TX_HIGH_SPEED_SELECT = 2;
    localparam int UBRG_TX_SHIFT_EMPTY = 1;
    localparam int UBRG_RX_PORT_ENABLE = 7;
    localparam int UBRG_BC_RECEIVE_IDLE = 6;
    localparam int UBRG_BC_WIDE_DIVISOR_SELECT = 3;
    localparam int UBRG_RS_RX_LEVEL = 0;
    localparam int UBRG_RS_SYNC_MASTER = 1;
    localparam int UBRG_RS_SYNC_SLAVE = 2;
    localparam int UBRG_RS_CLOCK_OUT = 3;

    // ==========================================================
    // Reset values and writable masks
    // ==========================================================
    localparam logic [7:0] UBRG_RST_TX_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] UBRG_RST_RX_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] UBRG_RST_BAUD_CONTROL = 8'h00;
    localparam logic [7:0] UBRG_RST_DIVISOR = 8'h00;
    localparam logic [7:0] UBRG_WMASK_TX = 8'hfd;
    localparam logic [7:0] UBRG_WMASK_RX = 8'hf8;
    localparam logic [7:0] UBRG_WMASK_BC = 8'hbb;

    // ==========================================================
    // Prescale counts, stored as the last count (divide minus one)
    // ==========================================================
    localparam int UBRG_DIV_SLOW = 64;
    localparam int UBRG_DIV_FAST = 16;
    localparam int UBRG_DIV_SYNC = 4;
    localparam logic [5:0] UBRG_PRE_LAST_SLOW = 6'(UBRG_DIV_SLOW - 1);
    localparam logic [5:0] UBRG_PRE_LAST_FAST = 6'(UBRG_DIV_FAST - 1);
    localparam logic [5:0] UBRG_PRE_LAST_SYNC = 6'(UBRG_DIV_SYNC - 1);
    localparam int UBRG_VOTE_SAMPLES = 3;

    // Mode bits steering the generator
    typedef struct packed {
        logic sync_mode;
        logic clock_source_master;
        logic high_speed_select;
        logic wide_divisor_select;
    } ubrg_cfg_s;

endpackage

// file: tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench
    import ubrg_pkg::*;
;
    typedef struct packed {
        logic [7:0] tx;
        logic [7:0] bc;
        logic [7:0] hi;
        logic [7:0] lo;
        int per;
    } ubrg_row_s;
    ubrg_row_s rows [6] = '{'{8'h00, 8'h00, 8'h05, 8'h02, 192}, '{8'h04, 8'h00, 8'h05, 8'h02, 48},
        '{8'h00, 8'h08, 8'h01, 8'h00, 4112}, '{8'h04, 8'h08, 8'h00, 8'h05, 24},
        '{8'h94, 8'h00, 8'h07, 8'h01, 8}, '{8'h90, 8'h08, 8'h01, 8'h01, 1032}};
    logic [4:0] ra [5] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h10};
    logic [7:0] rr [5] = '{8'h02, 8'h00, 8'h40, 8'h00, 8'h00};
    logic [7:0] rf [3] = '{8'hff, 8'hf8, 8'hfb};
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [4:0] avs_address = 5'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic rx_pin;
    logic bit_tick_q;
    logic rx_level_q;
    logic rx_level_valid_q;
    logic clock_out_q;
    logic clock_out_en_q;
    logic rx_lvl = 1'b1;
    logic glitch = 1'b0;
    logic [7:0] q;
    int err_total = 0;
    int checks_done = 0;
    int c;
    always #20 clk = ~clk;
    ubrg_top i_dut (.clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rx_pin(rx_pin),
        .bit_tick_q(bit_tick_q), .rx_level_q(rx_level_q), .rx_level_valid_q(rx_level_valid_q),
        .clock_out_q(clock_out_q), .clock_out_en_q(clock_out_en_q));
    ubrg_rx_model i_far (.clk(clk), .level(rx_lvl), .glitch(glitch), .rx_pin(rx_pin));
    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_cnt(input int got, input int exp);
        checks_done++;
        if (got != exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: count %0d expected %0d", $time, got, exp);
        end
    endtask
    // ==========================================================
    // Bus master: hold until waitrequest is seen low at a rising edge
    // ==========================================================
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
        input logic [3:0] be, output logic [7:0] rq);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        avs_write <= w;
        avs_read <= !w;
        // Values read here are those sampled at this edge
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        chk_cnt(int'(avs_waitrequest === 1'b0), 1);
        rq = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] dummy;
        bus(1'b1, a, d, 4'h1, dummy);
    endtask
    task automatic rd(input logic [4:0] a, output logic [7:0] rq);
        bus(1'b0, a, 8'h00, 4'h1, rq);
    endtask
    task automatic wait_ev(input logic v, output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while ((v ? rx_level_valid_q : bit_tick_q) !== 1'b1 && n < 6000);
    endtask
    task automatic cfg(input ubrg_row_s r);
        wr(UBRG_OFS_TX_STATUS_CONTROL, r.tx);
        wr(UBRG_OFS_BAUD_CONTROL, r.bc);
        wr(UBRG_OFS_BAUD_DIVISOR_HIGH, r.hi);
        wr(UBRG_OFS_BAUD_DIVISOR_LOW, r.lo);
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        final_report();
    end
    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        foreach (rows[i]) begin
            cfg(rows[i]);
            wait_ev(1'b0, c);
            wait_ev(1'b0, c);
            chk_cnt(c, rows[i].per);
        end
        wait_ev(1'b0, c);
        repeat (500) @(posedge clk);
        wr(UBRG_OFS_BAUD_DIVISOR_LOW, 8'h01);
        wait_ev(1'b0, c);
        chk_cnt(int'(c > 1000), 1);
        cfg(rows[3]);
        // Spike phase drifts over five votes, so every sample slot is hit once
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            rx_lvl <= k[0];
            glitch <= 1'b1;
            repeat (2) wait_ev(1'b1, c);
            repeat (5) begin
                wait_ev(1'b1, c);
                chk_val({7'h0, rx_level_q}, {7'h0, k[0]});
            end
        end
        wr(UBRG_OFS_TX_STATUS_CONTROL, 8'h10);
        wr(UBRG_OFS_BAUD_DIVISOR_LOW, 8'h00);
        wait_ev(1'b0, c);
        chk_cnt(c, 6000);
        chk_val({7'h0, clock_out_en_q}, 8'h00);
        rd(UBRG_OFS_RATE_STATUS, q);
        chk_val(q & 8'h06, 8'h04);
        wr(UBRG_OFS_TX_STATUS_CONTROL, 8'h90);
        wait_ev(1'b0, c);
        chk_val({7'h0, clock_out_en_q}, 8'h01);
        chk_val({7'h0, clock_out_q}, 8'h01);
        rd(UBRG_OFS_RATE_STATUS, q);
        chk_val(q & 8'h07, 8'h03);
        @(posedge clk);
        srst <= 1'b1;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        foreach (ra[i]) begin
            rd(ra[i], q);
            chk_val(q, rr[i]);
        end
        foreach (rf[i]) begin
            wr(ra[i], 8'hff);
            rd(ra[i], q);
            chk_val(q, rf[i]);
        end
        bus(1'b1, UBRG_OFS_BAUD_DIVISOR_LOW, 8'haa, 4'h0, q);
        rd(UBRG_OFS_BAUD_DIVISOR_LOW, q);
        chk_val(q, 8'h00);
        rd(5'h18, q);
        chk_val(q, 8'h00);
        final_report();
    end
endmodule
bind ubrg_top ubrg_checker i_chk (.clk(clk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .bit_tick_q(bit_tick_q),
    .rx_level_q(rx_level_q), .rx_level_valid_q(rx_level_valid_q), .clock_out_q(clock_out_q),
    .clock_out_en_q(clock_out_en_q));
`default_nettype wire

// file: tb/ubrg_checker.sv
`timescale 1ns/100ps
`default_nettype none
module ubrg_checker
    import ubrg_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic bit_tick_q,
    input wire logic rx_level_q,
    input wire logic rx_level_valid_q,
    input wire logic clock_out_q,
    input wire logic clock_out_en_q
);
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (srst);
    logic div_wr;
    logic rd_done;
    assign div_wr = avs_write && !avs_waitrequest && avs_byteenable[0] &&
        (avs_address == UBRG_OFS_BAUD_DIVISOR_HIGH || avs_address == UBRG_OFS_BAUD_DIVISOR_LOW);
    assign rd_done = avs_read && !avs_waitrequest;
    // ==========================================================
    // Generator
    // ==========================================================
    tick_pulse_a: assert property (bit_tick_q |=> !bit_tick_q)
        else $error("bit tick longer than one cycle");
    // Smallest prescale is 4, so a restart leaves at least three quiet cycles
    div_restart_a: assert property (div_wr |=> !bit_tick_q [*3])
        else $error("tick too soon after divisor write");
    slave_quiet_a: assert property (!clock_out_en_q |-> !clock_out_q)
        else $error("clock driven while not master");
    // ==========================================================
    // Receive vote
    // ==========================================================
    level_change_a: assert property ($changed(rx_level_q) |-> rx_level_valid_q)
        else $error("level changed without vote pulse");
    valid_pulse_a: assert property (rx_level_valid_q |=> !rx_level_valid_q)
        else $error("vote pulse longer than one cycle");
    // ==========================================================
    // Register reads
    // ==========================================================
    upper_zero_a: assert property (avs_readdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    unimpl_bit_a: assert property (rd_done && avs_address == UBRG_OFS_BAUD_CONTROL
        |-> avs_readdata[2] == 1'b0)
        else $error("unimplemented baud control bit set");
    status_zero_a: assert property (rd_done && avs_address == UBRG_OFS_RATE_STATUS
        |-> avs_readdata[7:4] == 4'h0)
        else $error("unused status bits set");
    cover property (bit_tick_q);
    cover property (rx_level_valid_q && !rx_level_q);
    cover property (clock_out_en_q && clock_out_q);
endmodule
`default_nettype wire

// file: tb/ubrg_rx_model.sv
`timescale 1ns/100ps
`default_nettype none
module ubrg_rx_model (
    input wire logic clk,
    input wire logic level,
    input wire logic glitch,
    output logic rx_pin
);
    logic [2:0] ph_q = 3'h0;
    logic pin_q = 1'b1;
    assign rx_pin = pin_q;
    always @(posedge clk) begin
        ph_q <= (ph_q == 3'h4) ? 3'h0 : ph_q + 3'h1;
        // One spike in five cycles never wins a vote of three, yet drifts
        pin_q <= (glitch && ph_q == 3'h4) ? !level : level;
    end
endmodule
`default_nettype wire
